// *** verilog/rsq_top.sv ***
// received signal strength and link quality reporting with axi4-lite registers
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "rsq_defines.svh"
`default_nettype none

module rsq_top
   import rsq_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // demodulator: per-symbol power and chip correlation
   input  wire logic              sym_stb,
   input  wire logic signed [7:0] power_dbm,
   input  wire logic              preamble_active,
   input  wire logic [4:0]        corr_match,
   // received octet stream
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   input  wire logic              rx_sop,
   input  wire logic              rx_eop,
   input  wire logic              rx_fcs_ok,
   output logic                   rx_ready,
   // receive buffer write port
   output logic                   buf_wr,
   output logic [7:0]             buf_data,
   // interrupt
   output logic                   irq
);

   // ==========================================================
   // decoding helpers
   function automatic logic map_ok(input logic [9:0] idx);
      map_ok = idx == `RSQ_IDX_AVG_CTRL  || idx == `RSQ_IDX_MODE_CTRL ||
               idx == `RSQ_IDX_STRENGTH  || idx == `RSQ_IDX_IRQ_STATUS ||
               idx == `RSQ_IDX_IRQ_MASK  || idx == `RSQ_IDX_LQI_LAST;
   endfunction

   function automatic logic [7:0] power_to_code(input logic signed [7:0] p);
      logic [7:0]  d;
      logic [13:0] t;
      d = 8'(p - 8'(`RSQ_POWER_FLOOR_DBM));
      t = {6'h0, d} * `RSQ_STRENGTH_SLOPE;
      if (p <= 8'(`RSQ_POWER_FLOOR_DBM))
         power_to_code = 8'h00;
      else if (p >= 8'(`RSQ_POWER_CEIL_DBM))
         power_to_code = 8'hff;
      else
         power_to_code = t[11:4];
   endfunction

   // ==========================================================
   // registers
   logic [7:0]  avg_ctrl_reg;
   logic [7:0]  mode_ctrl_reg;
   logic [7:0]  strength_reg;
   logic [7:0]  lqi_reg;
   logic [7:0]  lqi_last_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_mask_reg;

   // bus state
   logic [9:0]  aw_idx_reg;
   logic [31:0] w_data_reg;
   logic        w_strb0_reg;
   logic        aw_got;
   logic        w_got;
   logic        wr_fire;
   logic [9:0]  ar_idx;
   logic [7:0]  wbyte;

   assign aw_got  = !s_axi_awready;
   assign w_got   = !s_axi_wready;
   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign wbyte   = w_data_reg[7:0];
   assign ar_idx  = s_axi_araddr[11:2];

   // ==========================================================
   // write channel: address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RSQ_RESP_OKAY;
         aw_idx_reg    <= 10'h000;
         w_data_reg    <= 32'h0000_0000;
         w_strb0_reg   <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_idx_reg    <= s_axi_awaddr[11:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg   <= s_axi_wdata;
            w_strb0_reg  <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= map_ok(aw_idx_reg) ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ==========================================================
   // read channel: one cycle from address to data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RSQ_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= map_ok(ar_idx) ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
         case (ar_idx)
            `RSQ_IDX_AVG_CTRL:   s_axi_rdata <= {24'h0, avg_ctrl_reg};
            `RSQ_IDX_MODE_CTRL:  s_axi_rdata <= {24'h0, mode_ctrl_reg};
            `RSQ_IDX_STRENGTH:   s_axi_rdata <= {24'h0, strength_reg};
            `RSQ_IDX_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status_reg};
            `RSQ_IDX_IRQ_MASK:   s_axi_rdata <= {30'h0, irq_mask_reg};
            `RSQ_IDX_LQI_LAST:   s_axi_rdata <= {24'h0, lqi_last_reg};
            default:             s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // strength averaging
   logic       avg_restart;
   logic [7:0] avg_value;
   logic       avg_done;
   logic       req_wr;

   assign req_wr = wr_fire && w_strb0_reg && aw_idx_reg == `RSQ_IDX_MODE_CTRL &&
                   wbyte[`RSQ_STRENGTH_REQUEST];
   // a fresh request or a new window length discards a partial window
   assign avg_restart = req_wr || (wr_fire && w_strb0_reg && aw_idx_reg == `RSQ_IDX_AVG_CTRL);

   rsq_avg #(
      .CODE_W (8)
   ) u_avg (
      .aclk    (aclk),
      .aresetn (aresetn),
      .restart (avg_restart),
      .sel     (avg_ctrl_reg[`RSQ_AVG_SEL_HI:`RSQ_AVG_SEL_LO]),
      .sym_stb (sym_stb),
      .code    (power_to_code(power_dbm)),
      .avg     (avg_value),
      .done    (avg_done)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn)
         strength_reg <= 8'h00;
      else if (avg_done)
         strength_reg <= avg_value;
   end

   // ==========================================================
   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         avg_ctrl_reg <= `RSQ_AVG_CTRL_RESET;
         irq_mask_reg <= `RSQ_IRQ_MASK_RESET;
      end else if (wr_fire && w_strb0_reg) begin
         if (aw_idx_reg == `RSQ_IDX_AVG_CTRL)
            avg_ctrl_reg <= {wbyte[7:4], 4'h0};
         if (aw_idx_reg == `RSQ_IDX_IRQ_MASK)
            irq_mask_reg <= wbyte[1:0];
      end
   end

   // request self-clears when done is raised; done clears on a new request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ctrl_reg <= `RSQ_MODE_CTRL_RESET;
      end else begin
         if (wr_fire && w_strb0_reg && aw_idx_reg == `RSQ_IDX_MODE_CTRL) begin
            mode_ctrl_reg[`RSQ_APPEND_EN]        <= wbyte[`RSQ_APPEND_EN];
            mode_ctrl_reg[`RSQ_STRENGTH_REQUEST] <= wbyte[`RSQ_STRENGTH_REQUEST];
            if (wbyte[`RSQ_STRENGTH_REQUEST])
               mode_ctrl_reg[`RSQ_STRENGTH_DONE] <= 1'b0;
         end else if (avg_done && mode_ctrl_reg[`RSQ_STRENGTH_REQUEST]) begin
            mode_ctrl_reg[`RSQ_STRENGTH_REQUEST] <= 1'b0;
            mode_ctrl_reg[`RSQ_STRENGTH_DONE]    <= 1'b1;
         end
      end
   end

   // ==========================================================
   // link quality from preamble chip correlation
   logic [1:0] lqi_cnt_reg;
   logic [6:0] corr_sum_reg;
   logic [6:0] corr_sum_next;
   logic [13:0] lqi_scaled;

   assign corr_sum_next = corr_sum_reg + {2'h0, corr_match};
   // 3 x 32 chips = 96 maps onto 255 via x * 85 / 32
   assign lqi_scaled = {7'h00, corr_sum_next} * `RSQ_LQI_SCALE;

   always_ff @(posedge aclk) begin
      if (!aresetn || !preamble_active) begin
         lqi_cnt_reg  <= 2'd0;
         corr_sum_reg <= 7'h00;
      end else if (sym_stb && lqi_cnt_reg != `RSQ_LQI_SYMBOLS) begin
         lqi_cnt_reg  <= lqi_cnt_reg + 2'd1;
         corr_sum_reg <= corr_sum_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         lqi_reg <= 8'h00;
      else if (preamble_active && sym_stb && lqi_cnt_reg == `RSQ_LQI_SYMBOLS - 2'd1)
         lqi_reg <= lqi_scaled[12:5];
   end

   // ==========================================================
   // packet store sequencer
   rsq_state_type state_reg;
   logic          good_reg;
   logic          append_reg;
   logic          pkt_stored;

   assign pkt_stored = (state_reg == RSQ_LQI && !append_reg) || state_reg == RSQ_STRGTH;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg  <= RSQ_IDLE;
         rx_ready   <= 1'b1;
         good_reg   <= 1'b0;
         append_reg <= 1'b0;
      end else begin
         case (state_reg)
            RSQ_IDLE: begin
               if (rx_valid && rx_sop && !rx_eop)
                  state_reg <= RSQ_FWD;
            end
            RSQ_FWD: begin
               if (rx_valid && rx_eop) begin
                  // stall the source while the trailer octets go in
                  rx_ready   <= 1'b0;
                  good_reg   <= rx_fcs_ok;
                  append_reg <= rx_fcs_ok && mode_ctrl_reg[`RSQ_APPEND_EN];
                  state_reg  <= RSQ_LQI;
               end
            end
            RSQ_LQI: begin
               if (append_reg) begin
                  state_reg <= RSQ_STRGTH;
               end else begin
                  state_reg <= RSQ_IDLE;
                  rx_ready  <= 1'b1;
               end
            end
            RSQ_STRGTH: begin
               state_reg <= RSQ_IDLE;
               rx_ready  <= 1'b1;
            end
            default: begin
               state_reg <= RSQ_IDLE;
               rx_ready  <= 1'b1;
            end
         endcase
      end
   end

   // buffer writes: stream octets, then quality, then strength
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_wr       <= 1'b0;
         buf_data     <= 8'h00;
         lqi_last_reg <= 8'h00;
      end else begin
         buf_wr <= 1'b0;
         if (rx_valid && rx_ready && (state_reg == RSQ_FWD || rx_sop)) begin
            buf_wr   <= 1'b1;
            buf_data <= rx_data;
         end else if (state_reg == RSQ_LQI) begin
            buf_wr       <= 1'b1;
            buf_data     <= lqi_reg;
            lqi_last_reg <= lqi_reg;
         end else if (state_reg == RSQ_STRGTH) begin
            buf_wr   <= 1'b1;
            buf_data <= strength_reg;
         end
      end
   end

   // ==========================================================
   // interrupts: set beats a write-one clear in the same cycle
   logic [1:0] irq_set;
   logic [1:0] irq_clr;

   assign irq_set = {avg_done && mode_ctrl_reg[`RSQ_STRENGTH_REQUEST], pkt_stored && good_reg};
   assign irq_clr = (wr_fire && w_strb0_reg && aw_idx_reg == `RSQ_IDX_IRQ_STATUS) ?
                    wbyte[1:0] : 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= 2'h0;
         irq            <= 1'b0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
         irq            <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
      end
   end

endmodule

`default_nettype wire

// *** include/rsq_defines.svh ***
// offsets, field positions, reset values and timing counts of the signal quality block
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define RSQ_IDX_AVG_CTRL      10'h025
`define RSQ_IDX_MODE_CTRL     10'h03e
`define RSQ_IDX_STRENGTH      10'h210
`define RSQ_IDX_IRQ_STATUS    10'h300
`define RSQ_IDX_IRQ_MASK      10'h301
`define RSQ_IDX_LQI_LAST      10'h302

// ==========================================================
// field positions
`define RSQ_BEACON_IRQ_MASK   7
`define RSQ_WAKE_BEACON_SEL   6
`define RSQ_AVG_SEL_HI        5
`define RSQ_AVG_SEL_LO        4
`define RSQ_STRENGTH_REQUEST  7
`define RSQ_APPEND_EN         6
`define RSQ_STRENGTH_DONE     0
`define RSQ_IRQ_PACKET        0
`define RSQ_IRQ_STRENGTH      1

// ==========================================================
// reset values
`define RSQ_AVG_CTRL_RESET    8'h30
`define RSQ_MODE_CTRL_RESET   8'h00
`define RSQ_IRQ_MASK_RESET    2'h0

// ==========================================================
// strength mapping and link quality timing
`define RSQ_POWER_FLOOR_DBM   (-90)
`define RSQ_POWER_CEIL_DBM    (-35)
`define RSQ_STRENGTH_SLOPE    14'h004a
`define RSQ_LQI_SYMBOLS       2'd3
`define RSQ_LQI_SCALE         14'h0055

// ==========================================================
// bus answers
`define RSQ_RESP_OKAY         2'h0
`define RSQ_RESP_SLVERR       2'h2

`endif

// *** include/rsq_pkg.sv ***
// types shared by the signal quality block
`default_nettype none

package rsq_pkg;

   // ==========================================================
   // packet store sequencer, gray coded along its appending path; the LQI to IDLE exit flips both bits
   typedef enum logic [1:0] {
      RSQ_IDLE   = 2'b00,
      RSQ_FWD    = 2'b01,
      RSQ_LQI    = 2'b11,
      RSQ_STRGTH = 2'b10
   } rsq_state_type;

endpackage

`default_nettype wire

// *** verilog/rsq_avg.sv ***
// running strength averager over a selectable number of symbols
`default_nettype none

module rsq_avg #(
   parameter int CODE_W = 8
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // control
   input  wire logic              restart,
   input  wire logic [1:0]        sel,
   // samples
   input  wire logic              sym_stb,
   input  wire logic [CODE_W-1:0] code,
   // result
   output logic [CODE_W-1:0]      avg,
   output logic                   done
);

   logic [CODE_W+2:0] sum_reg;
   logic [3:0]        cnt_reg;
   logic [3:0]        target;
   logic [CODE_W+2:0] sum_next;

   // 1, 2, 4 or 8 symbols per average
   assign target   = 4'h1 << sel;
   assign sum_next = sum_reg + {3'h0, code};

   // ==========================================================
   // accumulate
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         sum_reg <= '0;
         cnt_reg <= 4'h0;
      end else if (sym_stb) begin
         if (cnt_reg + 4'h1 == target) begin
            sum_reg <= '0;
            cnt_reg <= 4'h0;
         end else begin
            sum_reg <= sum_next;
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end

   // ==========================================================
   // result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         avg  <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!restart && sym_stb && cnt_reg + 4'h1 == target) begin
            avg  <= CODE_W'(sum_next >> sel);
            done <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// *** tb/rsq_monitor.sv ***
// concurrent checks on the ports of the signal quality block
`default_nettype none

module rsq_monitor (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // demodulator and stream
   input wire logic        sym_stb,
   input wire logic        preamble_active,
   input wire logic [4:0]  corr_match,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_eop,
   input wire logic        rx_fcs_ok,
   input wire logic        rx_ready,
   input wire logic        buf_wr,
   input wire logic [7:0]  buf_data,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // reference correlation sum, kept until the next preamble
   logic [6:0] q_sum;
   logic [1:0] q_cnt;
   wire        eop_take = rx_valid && rx_ready && rx_eop;

   always_ff @(posedge aclk) begin
      if (!aresetn || !preamble_active) begin
         q_cnt <= 2'h0;
      end else if (sym_stb && q_cnt != 2'h3) begin
         q_cnt <= q_cnt + 2'h1;
         q_sum <= (q_cnt == 2'h0) ? 7'(corr_match) : q_sum + 7'(corr_match);
      end
   end

   // ==========================================================
   // properties
   property p_reset;
      disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !buf_wr && !irq;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not idle after reset");
   property p_fwd;
      rx_valid && rx_ready |=> buf_wr && buf_data == $past(rx_data);
   endproperty
   a_fwd: assert property (p_fwd) else $error("octet not stored");
   property p_trailer;
      eop_take |=> !rx_ready && buf_wr ##1 buf_wr;
   endproperty
   a_trailer: assert property (p_trailer) else $error("trailer missing");
   property p_bad;
      eop_take && !rx_fcs_ok |=> !rx_ready ##1 rx_ready;
   endproperty
   a_bad: assert property (p_bad) else $error("strength on bad packet");
   property p_quality;
      eop_take |=> ##1 buf_data == 8'((14'(q_sum) * 14'h0055) >> 5);
   endproperty
   a_quality: assert property (p_quality) else $error("quality octet wrong");
   property p_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write response late");
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_rhold;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer not retired");
endmodule

`default_nettype wire

// *** tb/rsq_src_model.sv ***
// demodulator and octet source in front of the signal quality block
`default_nettype none

module rsq_src_model (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // bench control
   input  wire logic signed [7:0] pwr,
   input  wire logic        go,
   input  wire logic [7:0]  len,
   input  wire logic [7:0]  base,
   input  wire logic        fcs,
   input  wire logic [4:0]  corr_c,
   output logic             busy,
   // demodulator side
   output logic             sym_stb,
   output logic signed [7:0] power_dbm,
   output logic             preamble_active,
   output logic [4:0]       corr_match,
   // octet stream
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             rx_sop,
   output logic             rx_eop,
   output logic             rx_fcs_ok,
   input  wire logic        rx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] tick;
   logic [2:0] nsym;
   logic [7:0] idx;
   logic [1:0] ph;

   assign sym_stb   = tick == 3'h7;
   assign busy      = ph != 2'h0;
   // fourth preamble symbol differs so a longer sum shows
   assign corr_match = (ph == 2'h1 && nsym < 3'h3) ? corr_c : 5'h1f - corr_c;
   assign rx_fcs_ok = rx_eop ? fcs : ~fcs;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick <= 3'h0;
         ph <= 2'h0;
         nsym <= 3'h0;
         idx <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_sop <= 1'b0;
         rx_eop <= 1'b0;
         preamble_active <= 1'b0;
         power_dbm <= 8'sh00;
      end else begin
         tick <= tick + 3'h1;
         power_dbm <= pwr;
         case (ph)
            2'h0: if (go) begin
               ph <= 2'h1;
               nsym <= 3'h0;
               preamble_active <= 1'b1;
            end
            2'h1: if (sym_stb) begin
               nsym <= nsym + 3'h1;
               if (nsym == 3'h3) begin
                  ph <= 2'h2;
                  preamble_active <= 1'b0;
                  idx <= 8'h00;
                  rx_valid <= 1'b1;
                  rx_data <= base;
                  rx_sop <= 1'b1;
                  rx_eop <= 1'b0;
               end
            end
            default: if (rx_ready) begin
               idx <= idx + 8'h01;
               rx_sop <= 1'b0;
               rx_data <= base + idx + 8'h01;
               rx_eop <= (idx + 8'h02 == len);
               if (rx_eop) begin
                  // released stream holds the inverted last octet, never the last octet
                  rx_valid <= 1'b0;
                  rx_eop <= 1'b0;
                  rx_data <= ~rx_data;
                  ph <= 2'h0;
               end
            end
         endcase
      end
   end
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the signal quality block
`include "rsq_defines.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, go, fcs, busy, irq, buf_wr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic sym_stb, preamble_active, rx_valid, rx_sop, rx_eop, rx_fcs_ok, rx_ready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic signed [7:0] power_dbm, pwr;
   logic [4:0] corr_match, corr_c;
   logic [7:0] rx_data, buf_data, len, base, rnd;
   logic [7:0] got[$];
   int err_count, total_checks, cyc;

   rsq_top i_rsq_top (.*);
   rsq_src_model i_rsq_src_model (.*);

   always #2 aclk = ~aclk;
   always @(posedge aclk) if (aresetn && buf_wr === 1'b1) got.push_back(buf_data);

   // ==========================================================
   // expectations and helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] scode(input int p);
      if (p <= -90) return 8'h00;
      if (p >= -35) return 8'hff;
      return 8'(((p + 90) * 74) >> 4);
   endfunction
   task automatic chk(input logic [31:0] s, e, input string m);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // register bus master
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] l, b;
      logic [4:0] c;
      int p, n;
      {aclk, aresetn, go, fcs, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {len, base, corr_c, cyc, err_count, total_checks} = '0;
      s_axi_wstrb = 4'h1;
      pwr = -8'sd60;
      rnd = 8'd98;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h094, d, r); chk(d, `RSQ_AVG_CTRL_RESET, "avg reset");
      rd(12'h0f8, d, r); chk(d, `RSQ_MODE_CTRL_RESET, "mode reset");
      rd(12'hc04, d, r); chk(d, 32'h0, "mask reset");
      rd(12'h004, d, r); chk({d[29:0], r}, `RSQ_RESP_SLVERR, "unmapped read");
      wr(12'h004, 32'hff, r); chk(r, `RSQ_RESP_SLVERR, "unmapped write");
      wr(12'h094, 32'hff, r); rd(12'h094, d, r); chk(d, 32'hf0, "avg bits");
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         p = (i == 0) ? -90 : (i == 1) ? -35 : (i == 2) ? -100 : -89 + int'(rnd % 53);
         pwr <= 8'(p);
         wr(12'h094, {26'h0, 2'(i), 4'h0}, r);
         wr(12'h0f8, 32'h80, r);
         n = 0;
         do begin
            rd(12'h0f8, d, r);
            n++;
         end while (d[0] !== 1'b1 && n < 100);
         chk(d[7], 1'b0, "request not cleared");
         rd(12'h840, d, r); chk(d, scode(p), "strength value");
      end
      rd(12'hc00, d, r); chk(d[1], 1'b1, "strength event");
      wr(12'h094, 32'h0, r);
      pwr <= -8'sd50;
      for (int j = 0; j < 6; j++) begin
         rnd = lfsr(rnd);
         l = 8'(2 + rnd % 6);
         rnd = lfsr(rnd);
         b = rnd;
         c = 5'(lfsr(rnd));
         {len, base, corr_c, fcs} <= {l, b, c, 1'(j)};
         wr(12'hc00, 32'h3, r);
         wr(12'h0f8, {25'h0, 1'(j >> 1), 6'h0}, r);
         wr(12'hc04, {31'h0, 1'(j < 4)}, r);
         got.delete();
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (busy !== 1'b0 && n < 400);
         repeat (6) @(posedge aclk);
         chk(32'(got.size()), 32'(l) + 32'(j == 3) + 1, "octet count");
         for (int k = 0; k < l; k++) chk(got[k], 8'(b + k), "packet octet");
         chk(got[l], 8'((3 * c * 85) / 32), "quality octet");
         rd(12'hc08, d, r); chk(d, 8'((3 * c * 85) / 32), "last quality");
         if (j == 3) chk(got[l + 1], scode(-50), "strength octet");
         chk(irq, (j == 1 || j == 3), "packet interrupt");
         wr(12'hc00, 32'h3, r);
         repeat (2) @(posedge aclk);
         chk(irq, 1'b0, "interrupt clear");
      end
      wrap_up();
   end
endmodule

bind rsq_top rsq_monitor i_rsq_monitor (.*);

`default_nettype wire
